// [rtl/tksp_defines.vh]
// constants for the touch key signal processor
`ifndef TKSP_DEFINES_VH
`define TKSP_DEFINES_VH
`define TKSP_SIG_W 12
`define TKSP_NKEYS 4
`define TKSP_CLK_HZ 10000000
`define TKSP_CAL_TIME_MS 1000
`define TKSP_CAL_CYCLES ((`TKSP_CLK_HZ / 1000) * `TKSP_CAL_TIME_MS)
`define TKSP_TMO_SHORT_S 10
`define TKSP_TMO_LONG_S 60
`define TKSP_TMO_SHORT_CYCLES (`TKSP_CLK_HZ * `TKSP_TMO_SHORT_S)
`define TKSP_TMO_LONG_CYCLES (`TKSP_CLK_HZ * `TKSP_TMO_LONG_S)
`define TKSP_INTEG_LIMIT 3
`define TKSP_THRESH_DEFAULT 4
`define TKSP_DRIFT_UP_DEFAULT 16
`define TKSP_DRIFT_DN_DEFAULT 128
`endif

// [rtl/tksp_key.v]
// one key channel: reference, drift, threshold, integrator, timeout
`timescale 1ns/1ps
`default_nettype none
`include "tksp_defines.vh"
module tksp_key #(
    parameter THRESH = `TKSP_THRESH_DEFAULT,
    parameter DRIFT_UP = `TKSP_DRIFT_UP_DEFAULT,
    parameter DRIFT_DN = `TKSP_DRIFT_DN_DEFAULT
) (
    input wire clk,
    input wire srst,
    input wire cal,
    input wire sample_valid,
    input wire [`TKSP_SIG_W-1:0] sample,
    input wire [31:0] tmo_limit,
    output reg detect,
    output reg timed_out
);
    reg [`TKSP_SIG_W-1:0] ref_level;
    reg [1:0] integ;
    reg [31:0] on_timer;
    reg [7:0] drift_cnt;
    reg recal_pending;
    wire [`TKSP_SIG_W:0] thresh_lvl;
    wire [`TKSP_SIG_W:0] release_lvl;
    wire [`TKSP_SIG_W:0] samp_x;
    wire below;
    wire above_release;
    // threshold always derived from current reference
    assign thresh_lvl = {1'b0, ref_level} - THRESH[`TKSP_SIG_W:0];
    assign release_lvl = thresh_lvl + (THRESH[`TKSP_SIG_W:0] >> 2);
    assign samp_x = {1'b0, sample};
    assign below = (ref_level >= THRESH[`TKSP_SIG_W-1:0]) && (samp_x < thresh_lvl);
    assign above_release = (samp_x > release_lvl);
    always @(posedge clk) begin
        if (srst) begin
            ref_level <= {`TKSP_SIG_W{1'b1}};
            integ <= 2'h0;
            on_timer <= 32'h0;
            drift_cnt <= 8'h00;
            detect <= 1'b0;
            timed_out <= 1'b0;
            recal_pending <= 1'b1;
        end else begin
            timed_out <= 1'b0;
            if (detect) begin
                if (on_timer >= tmo_limit) begin
                    // recalibrate this key only, next sample becomes reference
                    recal_pending <= 1'b1;
                    detect <= 1'b0;
                    integ <= 2'h0;
                    on_timer <= 32'h0;
                    timed_out <= 1'b1;
                end else begin
                    on_timer <= on_timer + 32'h1;
                end
            end else begin
                on_timer <= 32'h0;
            end
            if (sample_valid) begin
                if (cal || recal_pending) begin
                    ref_level <= sample;
                    recal_pending <= 1'b0;
                    drift_cnt <= 8'h00;
                    integ <= 2'h0;
                    detect <= 1'b0;
                end else if (detect && !(on_timer >= tmo_limit)) begin
                    if (above_release) begin
                        detect <= 1'b0;
                        integ <= 2'h0;
                    end
                end else if (!detect) begin
                    if (below) begin
                        if (integ == `TKSP_INTEG_LIMIT - 1) begin
                            detect <= 1'b1;
                            integ <= 2'h0;
                        end else begin
                            integ <= integ + 2'h1;
                        end
                        drift_cnt <= 8'h00;
                    end else begin
                        integ <= 2'h0;
                        // slow drift toward raw signal; upward is faster
                        if (sample != ref_level) begin
                            if ((sample > ref_level && drift_cnt >= DRIFT_UP - 1) ||
                                (sample < ref_level && drift_cnt >= DRIFT_DN - 1)) begin
                                drift_cnt <= 8'h00;
                                if (sample > ref_level) begin
                                    ref_level <= ref_level + 1'b1;
                                end else begin
                                    ref_level <= ref_level - 1'b1;
                                end
                            end else begin
                                drift_cnt <= drift_cnt + 8'h01;
                            end
                        end else begin
                            drift_cnt <= 8'h00;
                        end
                    end
                end
            end
        end
    end
endmodule
`default_nettype wire

// [rtl/tksp_top.v]
// four-key touch signal processor top level
`timescale 1ns/1ps
`default_nettype none
`include "tksp_defines.vh"
module tksp_top #(
    parameter CAL_CYCLES = `TKSP_CAL_CYCLES,
    parameter TMO_SHORT_CYCLES = `TKSP_TMO_SHORT_CYCLES,
    parameter TMO_LONG_CYCLES = `TKSP_TMO_LONG_CYCLES
) (
    input wire clk,
    input wire srst,
    input wire rollover_select,
    input wire timeout_select,
    input wire sample_valid,
    input wire [1:0] sample_key,
    input wire [`TKSP_SIG_W-1:0] sample_count,
    output reg [`TKSP_NKEYS-1:0] key_out,
    output reg calibrating,
    output wire [`TKSP_NKEYS-1:0] key_timeout
);
    // ==========================================
    // option pin synchronisers
    reg roll_s1;
    reg roll_s2;
    reg tmo_s1;
    reg tmo_s2;
    always @(posedge clk) begin
        if (srst) begin
            roll_s1 <= 1'b1;
            roll_s2 <= 1'b1;
            tmo_s1 <= 1'b1;
            tmo_s2 <= 1'b1;
        end else begin
            roll_s1 <= rollover_select;
            roll_s2 <= roll_s1;
            tmo_s1 <= timeout_select;
            tmo_s2 <= tmo_s1;
        end
    end
    wire [31:0] tmo_limit;
    assign tmo_limit = tmo_s2 ? TMO_LONG_CYCLES[31:0] : TMO_SHORT_CYCLES[31:0];
    // ==========================================
    // power-up calibration window
    reg [31:0] cal_cnt;
    always @(posedge clk) begin
        if (srst) begin
            cal_cnt <= 32'h0;
            calibrating <= 1'b1;
        end else if (calibrating) begin
            // every key keeps reloading its reference until the window closes
            if (cal_cnt >= CAL_CYCLES[31:0] - 32'h1) begin
                calibrating <= 1'b0;
            end else begin
                cal_cnt <= cal_cnt + 32'h1;
            end
        end
    end
    // ==========================================
    // key channels
    wire [`TKSP_NKEYS-1:0] det;
    genvar k;
    generate
        for (k = 0; k < `TKSP_NKEYS; k = k + 1) begin : g_key
            tksp_key u_key (
                .clk(clk),
                .srst(srst),
                .cal(calibrating),
                .sample_valid(sample_valid && (sample_key == k)),
                .sample(sample_count),
                .tmo_limit(tmo_limit),
                .detect(det[k]),
                .timed_out(key_timeout[k])
            );
        end
    endgenerate
    // ==========================================
    // rollover: keep reported keys, admit new ones lowest index first
    reg [`TKSP_NKEYS-1:0] next_out;
    reg [2:0] cnt;
    wire [2:0] roll_limit;
    integer i;
    assign roll_limit = roll_s2 ? 3'h2 : 3'h1;
    always @* begin
        next_out = {`TKSP_NKEYS{1'b0}};
        cnt = 3'h0;
        // held keys keep slots, but never more than the current limit
        for (i = 0; i < `TKSP_NKEYS; i = i + 1) begin
            if (key_out[i] && det[i] && (cnt < roll_limit)) begin
                next_out[i] = 1'b1;
                cnt = cnt + 3'h1;
            end
        end
        for (i = 0; i < `TKSP_NKEYS; i = i + 1) begin
            if (det[i] && !next_out[i] && (cnt < roll_limit)) begin
                next_out[i] = 1'b1;
                cnt = cnt + 3'h1;
            end
        end
    end
    always @(posedge clk) begin
        if (srst) begin
            key_out <= {`TKSP_NKEYS{1'b0}};
        end else begin
            key_out <= next_out;
        end
    end
endmodule
`default_nettype wire

// [verif/tksp_front.sv]
// burst front end model: one sample per send
`timescale 1ns/1ps
`default_nettype none
module tksp_front (
    input wire logic clk,
    output logic sample_valid,
    output logic [1:0] sample_key,
    output logic [11:0] sample_count
);
    initial {sample_valid, sample_key, sample_count} = 15'h0000;
    // idle lines show the inverse so a stale count is never read as fresh
    task send(input logic [1:0] k, input logic [11:0] c);
        @(posedge clk);
        #10 {sample_valid, sample_key, sample_count} = {1'b1, k, c};
        @(posedge clk);
        #10 {sample_valid, sample_key, sample_count} = {1'b0, ~k, ~c};
    endtask
endmodule
`default_nettype wire

// [verif/tksp_top_properties.sv]
// port assertions for the touch processor
`timescale 1ns/1ps
`default_nettype none
module tksp_top_properties #(
    parameter TMO_SHORT_CYCLES = 50,
    parameter TMO_LONG_CYCLES = 200
) (
    input wire logic clk,
    input wire logic srst,
    input wire logic rollover_select,
    input wire logic timeout_select,
    input wire logic sample_valid,
    input wire logic [1:0] sample_key,
    input wire logic [3:0] key_out,
    input wire logic calibrating,
    input wire logic [3:0] key_timeout
);
    int on0;
    int lim;
    assign lim = timeout_select ? TMO_LONG_CYCLES : TMO_SHORT_CYCLES;
    // cycles key 0 has shown touched, to bound its on-duration
    always @(posedge clk) on0 <= key_out[0] ? on0 + 1 : 0;
    default clocking @(posedge clk); endclocking
    default disable iff (srst);
    sequence s_tmo_end;
        key_timeout[0] ##1 !key_timeout[0] && !key_out[0];
    endsequence
    a_cal_hold: assert property ($fell(srst) |-> calibrating [*8])
        else $error("early cal end");
    a_cal_quiet: assert property (calibrating && $past(calibrating) |-> key_out == 4'h0)
        else $error("key shown in cal");
    a_two_max: assert property ($countones(key_out) <= 2)
        else $error("over two keys");
    a_one_only: assert property (!rollover_select [*4] |-> $countones(key_out) <= 1)
        else $error("over one key");
    a_rise_cause: assert property ($rose(key_out[0]) |->
        $past(sample_valid && sample_key == 2'h0, 2)) else $error("rise without sample");
    a_tmo_end: assert property (key_timeout[0] |-> s_tmo_end)
        else $error("timeout kept key");
    a_tmo_span: assert property (key_timeout[0] |->
        on0 >= lim - 4 && on0 <= lim + 2 && key_timeout[3:1] == 3'h0) else $error("bad timeout");
    a_on_bound: assert property (key_out[0] |-> on0 <= lim + 2)
        else $error("held too long");
endmodule
bind tksp_top tksp_top_properties #(.TMO_SHORT_CYCLES(TMO_SHORT_CYCLES),
    .TMO_LONG_CYCLES(TMO_LONG_CYCLES)) u_props (.clk, .srst, .rollover_select,
    .timeout_select, .sample_valid, .sample_key, .key_out, .calibrating, .key_timeout);
`default_nettype wire

// [verif/tksp_top_test.sv]
// self-checking bench for the touch processor
`timescale 1ns/1ps
`default_nettype none
module tksp_top_test;
    logic clk = 1'b0;
    logic srst = 1'b1;
    logic rollover_select = 1'b1;
    logic timeout_select = 1'b0;
    logic sample_valid, calibrating;
    logic [1:0] sample_key;
    logic [11:0] sample_count;
    logic [3:0] key_out, key_timeout;
    int fail_count = 0, tests_run = 0, n;
    // key, sample count, expected outputs; every reference is 100
    logic [19:0] rows [0:22] = '{20'h005F0, 20'h005F0, 20'h00640, 20'h005F0, 20'h005F0,
        20'h00600, 20'h005F0, 20'h005F0, 20'h005F1, 20'h00611, 20'h00620, 20'h105F0,
        20'h105F0, 20'h105F2, 20'h205F2, 20'h205F2, 20'h205F6, 20'h305F6, 20'h305F6,
        20'h305F6, 20'h1064C, 20'h20648, 20'h30640};
    always #50 clk = ~clk;
    tksp_top #(.CAL_CYCLES(20), .TMO_SHORT_CYCLES(50), .TMO_LONG_CYCLES(200)) u_tksp_top (
        .clk, .srst, .rollover_select, .timeout_select, .sample_valid, .sample_key,
        .sample_count, .key_out, .calibrating, .key_timeout);
    tksp_front u_tksp_front (.clk, .sample_valid, .sample_key, .sample_count);
    task chk(input logic [3:0] got, input logic [3:0] exp);
        tests_run++;
        if (got !== exp) begin
            fail_count++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task test_done;
        $display("checks %0d mismatches %0d", tests_run, fail_count);
        if (fail_count == 0 && tests_run > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    task tick;
        @(posedge clk);
        #10;
    endtask
    task hit(input logic [1:0] k, input logic [11:0] c, input int r);
        repeat (r) u_tksp_front.send(k, c);
        tick;
    endtask
    task wait_for(input int lim, input bit tmo);
        n = 0;
        while ((tmo ? key_timeout === 4'h0 : calibrating !== 1'b0) && n < lim) begin
            tick;
            n++;
        end
        if (n >= lim) begin
            fail_count++;
            test_done;
        end
    endtask
    initial begin
        repeat (4) tick;
        chk(key_out, 4'h0);
        chk({3'h0, calibrating}, 4'h1);
        srst = 1'b0;
        for (int k = 0; k < 4; k++) hit(k[1:0], 12'h064, 1);
        wait_for(40, 1'b0);
        foreach (rows[i]) begin
            hit(rows[i][17:16], rows[i][15:4], 1);
            tick;
            chk(key_out, rows[i][3:0]);
        end
        hit(2'h0, 12'h05F, 3);
        wait_for(80, 1'b1);
        chk(key_timeout, 4'h1);
        tick;
        chk(key_out, 4'h0);
        hit(2'h0, 12'h05F, 4);
        chk(key_out, 4'h0);
        hit(2'h0, 12'h05A, 3);
        chk(key_out, 4'h1);
        hit(2'h0, 12'h064, 1);
        rollover_select = 1'b0;
        hit(2'h1, 12'h05F, 3);
        hit(2'h2, 12'h05F, 3);
        chk(key_out, 4'h2);
        hit(2'h1, 12'h064, 1);
        tick;
        chk(key_out, 4'h4);
        hit(2'h2, 12'h064, 1);
        timeout_select = 1'b1;
        hit(2'h3, 12'h05F, 3);
        wait_for(300, 1'b1);
        chk(key_timeout, 4'h8);
        chk({3'h0, n > 150}, 4'h1);
        hit(2'h0, 12'h064, 16);
        hit(2'h0, 12'h05B, 3);
        chk(key_out, 4'h1);
        test_done;
    end
endmodule
`default_nettype wire
